// File: ccpl_checker.sv
// port-level assertions for the card coupler host control block
`timescale 1ns/100ps
module ccpl_checker (
	input wire core_clk,
	input wire resetn,
	input wire spi_clk,
	input wire spi_cs_n,
	input wire spi_miso,
	input wire spi_miso_oe,
	input wire io_pullup_enable,
	input wire card_supply_undervoltage,
	input wire card_supply_overload,
	input wire io_pullup_on,
	input wire io_xlat_en,
	input wire supply_conv_en,
	input wire card_pdn_active
);
	////////////////////////////////
	// one clock domain, async reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	AST_PU_ON: assert property (io_pullup_enable[*5] |-> io_pullup_on)
		else $error("pull-up not connected");
	AST_PU_OFF: assert property ((!io_pullup_enable)[*5] |-> !io_pullup_on)
		else $error("pull-up connected while disabled");
	AST_OE_IDLE: assert property (spi_cs_n[*6] |-> !spi_miso_oe && !spi_miso)
		else $error("serial out driven while deselected");
	AST_OE_FRAME: assert property (!spi_cs_n[*6] |-> spi_miso_oe)
		else $error("serial out not driven in frame");
	AST_XLAT_IDLE: assert property (spi_cs_n[*6] |-> !io_xlat_en)
		else $error("translator on while deselected");
	AST_NO_CMD: assert property (spi_cs_n[*8] |-> !$rose(supply_conv_en))
		else $error("supply started outside a frame");
	AST_UV: assert property (spi_cs_n[*6] ##0 ($rose(card_supply_undervoltage)
		&& !card_supply_overload) |=> $stable(supply_conv_en)[*4])
		else $error("supply changed on undervoltage");
	AST_OVLD: assert property ($rose(card_supply_overload) && supply_conv_en
		|-> ##[1:8] card_pdn_active) else $error("no power-down on overload");
	AST_PDN_LEN: assert property ($rose(card_pdn_active) |-> ##[1:1000] !card_pdn_active)
		else $error("power-down never ends");
	AST_MISO_HOLD: assert property ((spi_miso_oe && spi_clk)[*8] |-> $stable(spi_miso))
		else $error("serial out moved while clock high");
	COV_FRAME: cover property ($fell(spi_cs_n));
	COV_UV: cover property ($rose(card_supply_undervoltage));
	COV_PDN: cover property ($rose(card_pdn_active));
endmodule // ccpl_checker
bind ccpl_top ccpl_checker i_chk (.*);

// File: ccpl_defs.vh
// constants for the card coupler host control block
`ifndef CCPL_DEFS_VH
`define CCPL_DEFS_VH
// command byte layout
`define CCPL_CMD_ADDR_HI    7
`define CCPL_CMD_ADDR_LO    6
`define CCPL_CMD_ASYNC_BIT  5
`define CCPL_CMD_SUPPLY_BIT 4
// status byte layout
`define CCPL_ST_ADDR0_BIT   0
`define CCPL_ST_ADDR1_BIT   1
`define CCPL_ST_UVLO_BIT    2
`define CCPL_ST_OVLD_BIT    3
`define CCPL_ST_PRES_BIT    4
// reset values
`define CCPL_CTRL_RST       8'h00
// power-down step time, ns, and cycles at 8 ns
`define CCPL_PDN_STEP_NS    1000
`define CCPL_CLK_NS         8
`define CCPL_PDN_STEP_CYC   ((`CCPL_PDN_STEP_NS + `CCPL_CLK_NS - 1) / `CCPL_CLK_NS)
`endif

// File: ccpl_host_model.sv
// serial bus master model facing the coupler
`timescale 1ns/100ps
module ccpl_host_model (
	input wire core_clk,
	input wire spi_miso,
	input wire spi_miso_oe,
	output reg spi_clk,
	output reg spi_cs_n,
	output reg spi_mosi
);
	integer i; // bit index
	////////////////////////////////
	// one framed exchange, msb first, 8-cycle half periods
	task xfer(input [7:0] cmd, input integer nb, output [7:0] st);
	begin
		st = 8'h00;
		@(posedge core_clk) spi_cs_n <= 1'b0;
		for (i = 0; i < nb; i = i + 1) begin
			spi_mosi <= cmd[7-i];
			repeat (8) @(posedge core_clk);
			spi_clk <= 1'b1;
			st = {st[6:0], spi_miso_oe ? spi_miso : 1'b0}; // released line pulled down
			repeat (8) @(posedge core_clk);
			spi_clk <= 1'b0;
		end
		spi_mosi <= ~spi_mosi; // idle line no longer shows last bit
		repeat (8) @(posedge core_clk);
		spi_cs_n <= 1'b1;
		repeat (8) @(posedge core_clk);
	end
	endtask
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
endmodule // ccpl_host_model

// File: ccpl_sync.v
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/100ps
module ccpl_sync #(
	parameter W = 1
) (
	core_clk,
	resetn,
	d_in,
	q_out
);
	input  wire         core_clk;  // system clock
	input  wire         resetn;    // async reset, low active
	input  wire [W-1:0] d_in;      // raw inputs
	output wire [W-1:0] q_out;     // synchronised inputs

	////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_reg;  // first stage, read by second only
			reg s2_reg;  // second stage
			// two flops per bit
			always @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end else begin
					s1_reg <= d_in[i];
					s2_reg <= s1_reg;
				end
			end
			assign q_out[i] = s2_reg;
		end
	endgenerate
endmodule // ccpl_sync

// File: ccpl_top.v
// host control and status logic of the card coupler
`timescale 1ns/100ps
`include "ccpl_defs.vh"
module ccpl_top #(
	parameter [1:0] CHIP_ADDR = 2'h0  // board strap address
) (
	core_clk,
	resetn,
	spi_clk,
	spi_cs_n,
	spi_mosi,
	spi_miso,
	spi_miso_oe,
	io_pullup_enable,
	card_supply_undervoltage,
	card_supply_overload,
	card_present_n,
	io_pullup_on,
	io_xlat_en,
	supply_conv_en,
	card_pdn_active
);
	input  wire core_clk;                 // system clock
	input  wire resetn;                   // async reset, low active
	input  wire spi_clk;                  // serial clock pin
	input  wire spi_cs_n;                 // chip select, low active
	input  wire spi_mosi;                 // serial data in
	output reg  spi_miso;                 // serial data out level
	output reg  spi_miso_oe;              // serial out drive enable
	input  wire io_pullup_enable;         // pull-up enable pin
	input  wire card_supply_undervoltage; // comparator, supply low
	input  wire card_supply_overload;     // comparator, supply overload
	input  wire card_present_n;           // card detect, low active
	output reg  io_pullup_on;             // pull-up switch
	output reg  io_xlat_en;               // data translator enable
	output reg  supply_conv_en;           // card supply converter run
	output reg  card_pdn_active;          // power-down sequence running

	////////////////////////////////////////////////////////////////////////
	// overview: pins are synchronised first; a frame shifter takes the
	// command while the status byte goes out; the command applies when
	// chip select rises after a full byte; a small state machine runs
	// the card supply, which an undervoltage never touches

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	// every outside pin but clock and reset passes two flops before any logic reads it
	// cs and card detect pass inverted, so a cleared synchroniser
	// reads deselected and no card: no false frame after reset
	wire [6:0] sy;
	ccpl_sync #(.W(7)) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.d_in     ({spi_clk, ~spi_cs_n, spi_mosi, io_pullup_enable,
		            card_supply_undervoltage, card_supply_overload, ~card_present_n}),
		.q_out    (sy)
	);
	wire s_sck  = sy[6];  // serial clock
	wire s_csn  = ~sy[5]; // chip select, low active
	wire s_mosi = sy[4];  // data in
	wire s_pue  = sy[3];  // pull-up enable
	wire s_uv   = sy[2];  // undervoltage
	wire s_ov   = sy[1];  // overload
	wire s_pres = sy[0];  // card present

	////////////////////////////////////////////////////////////////////////
	// serial clock edge detect
	// clock idles low and the delay flop clears low: no false edge
	// rise samples data in, fall moves the next status bit out
	reg  sck_d_reg;  // delayed serial clock
	wire sck_rise = s_sck & ~sck_d_reg;
	wire sck_fall = ~s_sck & sck_d_reg;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			sck_d_reg <= 1'b0;
		else
			sck_d_reg <= s_sck;
	end

	////////////////////////////////////////////////////////////////////////
	// frame shifter state
	// all shifting stops while chip select is high
	reg [7:0] rx_reg;      // incoming command bits
	reg [7:0] tx_reg;      // outgoing status bits
	reg [3:0] cnt_reg;     // bits taken this frame
	reg       csn_d_reg;   // delayed chip select
	reg       fault_reg;   // sticky overload record
	reg       async_reg;   // asynchronous mode chosen
	reg       sel_reg;     // sub-address selected
	reg       sup_req_reg; // host asks supply on
	// chip select fall, seen after the synchroniser
	wire      frame_start = csn_d_reg & ~s_csn;
	wire [7:0] status_byte;
	// status byte is sampled once, at the start of the frame
	// upper three bits carry nothing
	assign status_byte[7:5]                = 3'h0;
	assign status_byte[`CCPL_ST_PRES_BIT]  = s_pres;
	assign status_byte[`CCPL_ST_OVLD_BIT]  = fault_reg;
	assign status_byte[`CCPL_ST_UVLO_BIT]  = s_uv;
	assign status_byte[`CCPL_ST_ADDR1_BIT] = CHIP_ADDR[1];
	assign status_byte[`CCPL_ST_ADDR0_BIT] = CHIP_ADDR[0];

	// shift status out, command in, within one frame
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_reg    <= `CCPL_CTRL_RST;
			tx_reg    <= `CCPL_CTRL_RST;
			cnt_reg   <= 4'h0;
			csn_d_reg <= 1'b1;
		end else begin
			csn_d_reg <= s_csn;
			// deselected: hold the count at zero, ignore the pins
			if (s_csn) begin
				cnt_reg <= 4'h0;
			end else if (frame_start) begin
				tx_reg  <= status_byte;
				cnt_reg <= 4'h0;
			end else begin
				// sample on rise, shift out on fall
				// counter stops at eight, later bits are dropped
				if (sck_rise && cnt_reg != 4'h8) begin
					rx_reg  <= {rx_reg[6:0], s_mosi};
					cnt_reg <= cnt_reg + 4'h1;
				end
				if (sck_fall)
					tx_reg <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// latch command at frame end when all eight bits arrived
	// a short frame changes nothing; a foreign address only deselects
	// mode and supply request hold until the next addressed command
	wire frame_end = ~csn_d_reg & s_csn;
	wire addr_hit  = rx_reg[`CCPL_CMD_ADDR_HI:`CCPL_CMD_ADDR_LO] == CHIP_ADDR;
	wire cmd_take  = frame_end & (cnt_reg == 4'h8); // full command only
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sel_reg     <= 1'b0;
			async_reg   <= 1'b0;
			sup_req_reg <= 1'b0;
		end else if (cmd_take) begin
			sel_reg <= addr_hit;
			if (addr_hit) begin
				async_reg   <= rx_reg[`CCPL_CMD_ASYNC_BIT];
				sup_req_reg <= rx_reg[`CCPL_CMD_SUPPLY_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// supply control: overload shuts down, undervoltage ignored
	localparam [2:0] ST_OFF = 3'h1;  // converter stopped
	localparam [2:0] ST_ON  = 3'h2;  // converter running
	localparam [2:0] ST_PDN = 3'h4;  // power-down sequence
	reg [2:0]  st_reg;   // supply state
	reg [15:0] pdn_reg;  // power-down step timer
	reg        ov_d_reg; // delayed overload for edge
	// step length as a full word, cut to the timer width on purpose
	wire [31:0] pdn_step = `CCPL_PDN_STEP_CYC;
	// undervoltage is reported in the status byte only
	// the power-down timer only runs in the power-down state
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg    <= ST_OFF;
			pdn_reg   <= 16'h0000;
			fault_reg <= 1'b0;
			ov_d_reg  <= 1'b0;
		end else begin
			ov_d_reg <= s_ov;
			// new overload beats clear by a fresh frame
			if (s_ov & ~ov_d_reg)
				fault_reg <= 1'b1;
			else if (cmd_take && addr_hit)
				fault_reg <= 1'b0;
			// one-hot supply states
			case (st_reg)
				ST_OFF: begin
					// restart only on request with no fault pending
					if (sup_req_reg && !fault_reg)
						st_reg <= ST_ON;
				end
				ST_ON: begin
					// undervoltage deliberately has no effect here
					if (s_ov || !sup_req_reg) begin
						st_reg  <= ST_PDN;
						pdn_reg <= pdn_step[15:0];
					end
				end
				ST_PDN: begin
					// count out the power-down step, then stop
					if (pdn_reg == 16'h0001)
						st_reg <= ST_OFF;
					pdn_reg <= pdn_reg - 16'h0001;
				end
				default: st_reg <= ST_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered pin outputs
	// every pin leaves a flip-flop; miso held low while deselected
	// translator follows select, async mode and chip select low
	// supply enable and power-down flag decode the one-hot state
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			spi_miso        <= 1'b0;
			spi_miso_oe     <= 1'b0;
			io_pullup_on    <= 1'b0;
			io_xlat_en      <= 1'b0;
			supply_conv_en  <= 1'b0;
			card_pdn_active <= 1'b0;
		end else begin
			spi_miso        <= ~s_csn & tx_reg[7];
			spi_miso_oe     <= ~s_csn;
			io_pullup_on    <= s_pue;
			io_xlat_en      <= ~s_csn & sel_reg & async_reg;
			supply_conv_en  <= st_reg == ST_ON;
			card_pdn_active <= st_reg == ST_PDN;
		end
	end
endmodule // ccpl_top

// File: ccpl_top_test.sv
// self-checking bench for the card coupler host control block
`timescale 1ns/100ps
module ccpl_top_test;
	localparam [1:0] ADDR = 2'h2; // strap address under test
	reg	core_clk, resetn, io_pullup_enable, card_present_n;
	reg	card_supply_undervoltage, card_supply_overload;
	wire	spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	wire	io_pullup_on, io_xlat_en, supply_conv_en, card_pdn_active;
	integer	fail_count, n_checks;
	reg [7:0]	st; // returned status
	ccpl_top #(.CHIP_ADDR(ADDR)) i_dut (.*);
	ccpl_host_model i_host (.*);
	always #4 core_clk = ~core_clk;
	////////////////////////////////
	task wt(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	// compare settled value, realign to edge
	task check(input [7:0] seen, input [7:0] exp, input [95:0] what);
	begin
		#1;
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("unexpected %0s: expected %h seen %h", what, exp, seen);
		end
		@(posedge core_clk);
	end
	endtask
	task conclude;
	begin
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	end
	endtask
	task t_pullup;
	begin
		io_pullup_enable <= 1'b1;
		wt(6); check(io_pullup_on, 1, "pullup");
		io_pullup_enable <= 1'b0;
		wt(6); check(io_pullup_on, 0, "pullup");
	end
	endtask
	task t_frame;
	begin
		card_supply_undervoltage <= 1'b1;
		card_present_n <= 1'b0;
		wt(8); i_host.xfer({ADDR, 6'h30}, 8, st);
		check(st & 8'h1f, {3'h0, 3'h5, ADDR}, "status");
		check(supply_conv_en, 1, "supply");
		check(io_xlat_en, 0, "xlat");
		fork
			i_host.xfer({ADDR, 6'h30}, 8, st);
			begin wt(60); check(io_xlat_en, 1, "xlat"); end
		join
		card_supply_undervoltage <= 1'b0;
		wt(8); check(supply_conv_en, 1, "uv");
	end
	endtask
	task t_refuse;
	begin
		i_host.xfer({ADDR, 6'h00}, 7, st);
		check(supply_conv_en, 1, "short");
		i_host.xfer({~ADDR, 6'h00}, 8, st);
		check(supply_conv_en, 1, "addr");
		fork
			i_host.xfer({~ADDR, 6'h00}, 8, st);
			begin wt(60); check(io_xlat_en, 0, "xlat"); end
		join
	end
	endtask
	task t_ovld;
	begin
		card_supply_overload <= 1'b1;
		wt(10); check(card_pdn_active, 1, "pdn");
		wt(1000); check(supply_conv_en, 0, "supply");
		card_supply_overload <= 1'b0;
		i_host.xfer({ADDR, 6'h00}, 8, st);
		check(st & 8'h1f, {3'h0, 3'h6, ADDR}, "fault");
	end
	endtask
	initial begin
		fail_count = 0;
		n_checks = 0;
		core_clk = 1'b0;
		resetn = 1'b0;
		io_pullup_enable = 1'b0;
		card_present_n = 1'b1;
		card_supply_undervoltage = 1'b0;
		card_supply_overload = 1'b0;
		wt(2); resetn <= 1'b1;
		wt(6); t_pullup;
		t_frame;
		t_refuse;
		t_ovld;
		conclude;
	end
	initial begin
		wt(10000);
		fail_count = fail_count + 1;
		conclude;
	end
endmodule // ccpl_top_test
